// ---- src/bps_pkg.sv ----
// Package with constants and types of the buck protection and strap logic.
// Functional notes
// - Stop switching while over-temperature is indicated.
// - Low-side limit active blocks high-side turn-on.
// - Valley limit strap selects 4.6/6.2/6.8 A.
// - Accepted high-side limit ends on-time at once.
// - Ignore high-side limit during 108 ns blanking.
// - Count up on cycles with low-side limit.
// - Count down otherwise; saturate at 0000/1111.
// - Full count: both switches off, three soft-starts.
// - After hiccup wait, start fresh soft-start.
// - Hiccup protection active in every sub-phase of run.
// - Blocked or skipped turn-on counts as overload.
// - Rate strap selects 400/565/790 kHz.
// - Two voltage straps select nine output voltages.
// - Latch straps once after analog supply stabilises.
// - Each strap decodes as low, high or open.
package bps_pkg;

    // Clock and timing.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned BLANK_NS      = 108;
    localparam logic [3:0]  BLANK_CYC     =
        4'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Switching rates in kHz and their periods in clock cycles.
    localparam logic [9:0] RATE_OPEN_KHZ = 10'd400;
    localparam logic [9:0] RATE_LOW_KHZ  = 10'd565;
    localparam logic [9:0] RATE_HIGH_KHZ = 10'd790;
    localparam logic [8:0] PER_OPEN = 9'(CLK_HZ / (400 * 1000));
    localparam logic [8:0] PER_LOW  = 9'(CLK_HZ / (565 * 1000));
    localparam logic [8:0] PER_HIGH = 9'(CLK_HZ / (790 * 1000));

    // Valley limit levels in units of 0.1 A.
    localparam logic [6:0] LIM_LOW_DA  = 7'd46;
    localparam logic [6:0] LIM_HIGH_DA = 7'd62;
    localparam logic [6:0] LIM_OPEN_DA = 7'd68;

    // Output voltages in mV.
    localparam logic [11:0] MV_3300 = 12'd3300;
    localparam logic [11:0] MV_2500 = 12'd2500;
    localparam logic [11:0] MV_1800 = 12'd1800;
    localparam logic [11:0] MV_1500 = 12'd1500;
    localparam logic [11:0] MV_1200 = 12'd1200;
    localparam logic [11:0] MV_1000 = 12'd1000;
    localparam logic [11:0] MV_900  = 12'd900;
    localparam logic [11:0] MV_800  = 12'd800;
    localparam logic [11:0] MV_700  = 12'd700;

    // Overload counter and hiccup wait.
    localparam logic [3:0] CNT_FULL = 4'hF;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam int unsigned HW_W    = 20;

    // Register offsets.
    localparam logic [4:0] REG_STATUS = 5'h00;
    localparam logic [4:0] REG_MASK   = 5'h04;
    localparam logic [4:0] REG_CTRL   = 5'h08;
    localparam logic [4:0] REG_CONFIG = 5'h0C;
    localparam logic [4:0] REG_STATE  = 5'h10;

    // Status and mask bit positions, and reset values.
    localparam int unsigned EV_OT    = 0;
    localparam int unsigned EV_HICC  = 1;
    localparam int unsigned EV_TRUNC = 2;
    localparam int unsigned EV_SKIP  = 3;
    localparam logic [3:0]  MASK_RST = 4'h0;
    localparam logic        RUN_RST  = 1'b1;
    localparam int unsigned CTRL_RUN = 0;

    // Config and state readback field positions.
    localparam int unsigned CF_MV   = 0;
    localparam int unsigned CF_KHZ  = 12;
    localparam int unsigned CF_LIM  = 22;
    localparam int unsigned SR_CNT  = 0;
    localparam int unsigned SR_PH   = 4;
    localparam int unsigned SR_HS   = 6;
    localparam int unsigned SR_LS   = 7;
    localparam int unsigned SR_VAL  = 8;

    // Decoded strap level.
    typedef enum logic [1:0] {STRAP_LOW, STRAP_HIGH, STRAP_OPEN} bps_strap_e;

    // Operating phase.
    typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_HICCUP} bps_phase_e;

    // Strap pin sensed with pull-up and with pull-down.
    typedef struct packed {
        logic pu;
        logic pd;
    } bps_sense_s;

    // All inputs arriving from outside the clock domain.
    typedef struct packed {
        logic       analog_ok;
        logic       over_temp;
        logic       ls_valley_limit_strap;
        logic       hs_valley_limit_strap;
        logic       pwm_req;
        bps_sense_s vout_strap_hi;
        bps_sense_s vout_strap_lo;
        bps_sense_s switch_rate_strap;
        bps_sense_s valley_limit_strap;
    } bps_pins_s;

    // Latched configuration.
    typedef struct packed {
        logic [11:0] vout_mv;
        logic [9:0]  rate_khz;
        logic [6:0]  limit_da;
        logic [8:0]  period;
    } bps_cfg_s;

    // Register port request.
    typedef struct packed {
        logic [4:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bps_bus_s;

endpackage

// ---- src/bps_sync.sv ----
// Three-stage synchroniser with agreement filter for all pin inputs.
`timescale 1ns/1ps
module bps_sync (
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               resetn,
    // Raw and filtered pins.
    input  wire bps_pkg::bps_pins_s pin_in,
    output bps_pkg::bps_pins_s      pin_out
);
    import bps_pkg::*;

    // Stage registers and the accepted value.
    typedef struct packed {
        bps_pins_s s1;
        bps_pins_s s2;
        bps_pins_s s3;
        bps_pins_s q;
    } bps_sync_s;

    bps_sync_s st_r;   // Registered state.
    bps_sync_s st_nxt; // Next state.

    // A bit is accepted only where stages two and three agree.
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.q  = (st_r.s2 & ~(st_r.s2 ^ st_r.s3)) | (st_r.q & (st_r.s2 ^ st_r.s3));
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_out = st_r.q;
endmodule

// ---- src/bps_sat_counter.sv ----
// Saturating 4-bit up/down overload counter.
`timescale 1ns/1ps
module bps_sat_counter (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       resetn,
    // Control.
    input  wire logic       tick,
    input  wire logic       up,
    input  wire logic       clr,
    // Count.
    output logic [3:0]      count,
    output logic            full
);
    import bps_pkg::*;

    // Counter state.
    typedef struct packed {
        logic [3:0] cnt;
    } bps_cnt_s;

    bps_cnt_s st_r;   // Registered state.
    bps_cnt_s st_nxt; // Next state.

    // Clear wins; otherwise a tick steps up or down without wrapping.
    always_comb begin
        st_nxt = st_r;
        if (clr) begin
            st_nxt.cnt = CNT_ZERO;
        end else if (tick && up) begin
            if (st_r.cnt != CNT_FULL) begin
                st_nxt.cnt = st_r.cnt + 4'h1;
            end
        end else if (tick) begin
            if (st_r.cnt != CNT_ZERO) begin
                st_nxt.cnt = st_r.cnt - 4'h1;
            end
        end
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count = st_r.cnt;
    assign full  = (st_r.cnt == CNT_FULL);
endmodule

// ---- src/bps_top.sv ----
// Protection, strap decoding and switch gating of the step-down controller.
`timescale 1ns/1ps
module bps_top #(
    // Soft-start duration in microseconds.
    parameter int unsigned SS_TIME_US = 2000
) (
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               resetn,
    // Analog indications and straps.
    input  wire bps_pkg::bps_pins_s pins,
    // Register port.
    input  wire bps_pkg::bps_bus_s  bus,
    output logic [31:0]             rdata,
    // Power switch drivers and soft-start restart.
    output logic                    hs_gate,
    output logic                    ls_gate,
    output logic                    ss_restart,
    // Latched configuration.
    output logic                    cfg_valid,
    output bps_pkg::bps_cfg_s       cfg,
    // Interrupt.
    output logic                    irq
);
    import bps_pkg::*;

    // Hiccup wait: three soft-start durations in clock cycles.
    localparam int unsigned HICC_CYC = 3 * SS_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam logic [HW_W-1:0] HICC_LOAD = HW_W'(HICC_CYC - 1);

    // Complete block state.
    typedef struct packed {
        bps_phase_e     phase;    // Operating phase.
        logic           valid;    // Straps latched.
        bps_cfg_s       cfg;      // Latched configuration.
        logic [8:0]     per;      // Switching period down-counter.
        logic           wait_on;  // Cycle still owes a turn-on.
        logic           blocked;  // Turn-on demand held back.
        logic           ls_seen;  // Low-side limit this cycle.
        logic           hs;       // High-side gate.
        logic           ls;       // Low-side gate.
        logic [3:0]     blank;    // Blanking down-counter.
        logic           inh;      // Delivery inhibited.
        logic [HW_W-1:0] hwait;   // Hiccup wait counter.
        logic           ss_pulse; // Soft-start request.
        logic [3:0]     status;   // Sticky events.
        logic [3:0]     mask;     // Interrupt mask.
        logic           run;      // Software run enable.
        logic [31:0]    rdata;    // Read data.
        logic           irq;      // Interrupt output.
    } bps_top_s;

    bps_top_s  st_r;    // Registered state.
    bps_top_s  st_nxt;  // Next state.
    bps_pins_s p;       // Synchronised pins.
    logic [3:0] cnt;    // Overload count.
    logic      cnt_full; // Counter at 1111.
    logic      cnt_tick; // Switching cycle boundary.
    logic      cnt_up;   // Overload seen in the cycle.
    logic      cnt_clr;  // Clear for retry or idle.
    logic [3:0] ev;      // Events of this cycle.

    // Decodes one strap from its pull-up and pull-down readings.
    function automatic bps_strap_e strap_dec(input bps_sense_s s);
        bps_strap_e r;
        r = STRAP_OPEN;
        if (s.pu && s.pd) begin
            r = STRAP_HIGH;
        end else if (!s.pu && !s.pd) begin
            r = STRAP_LOW;
        end
        return r;
    endfunction

    // Output voltage from the upper and lower voltage straps.
    function automatic logic [11:0] vout_dec(input bps_strap_e hi,
                                             input bps_strap_e lo);
        logic [11:0] v;
        v = MV_700;
        case ({hi, lo})
            {STRAP_LOW, STRAP_LOW}:   v = MV_3300;
            {STRAP_LOW, STRAP_HIGH}:  v = MV_2500;
            {STRAP_HIGH, STRAP_LOW}:  v = MV_1800;
            {STRAP_HIGH, STRAP_HIGH}: v = MV_1500;
            {STRAP_LOW, STRAP_OPEN}:  v = MV_1200;
            {STRAP_OPEN, STRAP_LOW}:  v = MV_1000;
            {STRAP_HIGH, STRAP_OPEN}: v = MV_900;
            {STRAP_OPEN, STRAP_HIGH}: v = MV_800;
            default:                  v = MV_700;
        endcase
        return v;
    endfunction

    // Full configuration from the synchronised straps.
    function automatic bps_cfg_s cfg_dec(input bps_pins_s q);
        bps_cfg_s c;
        c.vout_mv = vout_dec(strap_dec(q.vout_strap_hi),
                             strap_dec(q.vout_strap_lo));
        case (strap_dec(q.switch_rate_strap))
            STRAP_LOW: begin
                c.rate_khz = RATE_LOW_KHZ;
                c.period   = PER_LOW;
            end
            STRAP_HIGH: begin
                c.rate_khz = RATE_HIGH_KHZ;
                c.period   = PER_HIGH;
            end
            default: begin
                c.rate_khz = RATE_OPEN_KHZ;
                c.period   = PER_OPEN;
            end
        endcase
        case (strap_dec(q.valley_limit_strap))
            STRAP_LOW:  c.limit_da = LIM_LOW_DA;
            STRAP_HIGH: c.limit_da = LIM_HIGH_DA;
            default:    c.limit_da = LIM_OPEN_DA;
        endcase
        return c;
    endfunction

    // Every pin passes the three-stage filter before use.
    bps_sync u_sync (
        .clk     (clk),
        .resetn  (resetn),
        .pin_in  (pins),
        .pin_out (p)
    );

    // Overload integrator shared by all phases.
    bps_sat_counter u_cnt (
        .clk    (clk),
        .resetn (resetn),
        .tick   (cnt_tick),
        .up     (cnt_up),
        .clr    (cnt_clr),
        .count  (cnt),
        .full   (cnt_full)
    );

    // Next-state logic for phases, gating, registers and interrupt.
    always_comb begin
        st_nxt          = st_r;
        st_nxt.ss_pulse = 1'b0;
        ev              = 4'h0;
        cnt_tick        = 1'b0;
        cnt_up          = 1'b0;
        cnt_clr         = 1'b0;

        // Switching period runs once straps are latched.
        if (st_r.valid) begin
            if (st_r.per == 9'h000) begin
                st_nxt.per = st_r.cfg.period - 9'h001;
            end else begin
                st_nxt.per = st_r.per - 9'h001;
            end
        end

        case (st_r.phase)
            PH_IDLE: begin
                // Switches stay off until the analog supply is up.
                st_nxt.hs = 1'b0;
                st_nxt.ls = 1'b0;
                cnt_clr   = 1'b1;
                if (p.analog_ok) begin
                    st_nxt.cfg      = cfg_dec(p);
                    st_nxt.valid    = 1'b1;
                    st_nxt.per      = 9'h000;
                    st_nxt.wait_on  = 1'b0;
                    st_nxt.phase    = PH_RUN;
                    st_nxt.ss_pulse = 1'b1;
                end
            end
            PH_RUN: begin
                // Counting runs here in every sub-phase.
                cnt_tick = (st_r.per == 9'h000);
                cnt_up   = st_r.ls_seen | st_r.blocked | p.ls_valley_limit_strap;
                if (p.ls_valley_limit_strap) begin
                    st_nxt.ls_seen = 1'b1;
                end
                st_nxt.inh = p.over_temp | ~st_r.run;
                if (p.over_temp && !st_r.inh) begin
                    ev[EV_OT] = 1'b1;
                end
                if (p.over_temp || !st_r.run) begin
                    // Both switches off while hot or disabled.
                    st_nxt.hs      = 1'b0;
                    st_nxt.ls      = 1'b0;
                    st_nxt.wait_on = 1'b0;
                end else if (st_r.inh) begin
                    // Restart with a soft-start once cool again.
                    st_nxt.ss_pulse = 1'b1;
                end else if (st_r.per == 9'h000) begin
                    // Cycle boundary is the off clock event.
                    st_nxt.hs      = 1'b0;
                    st_nxt.ls      = 1'b1;
                    st_nxt.wait_on = 1'b1;
                    if (st_r.blocked && st_r.wait_on) begin
                        ev[EV_SKIP] = 1'b1;
                    end
                end else if (st_r.wait_on && p.pwm_req) begin
                    if (p.ls_valley_limit_strap) begin
                        // Demand waits while valley current is high.
                        st_nxt.blocked = 1'b1;
                    end else begin
                        st_nxt.hs      = 1'b1;
                        st_nxt.ls      = 1'b0;
                        st_nxt.wait_on = 1'b0;
                        st_nxt.blank   = BLANK_CYC;
                    end
                end else if (st_r.hs) begin
                    if (st_r.blank != 4'h0) begin
                        st_nxt.blank = st_r.blank - 4'h1;
                    end else if (p.hs_valley_limit_strap) begin
                        // Truncate the on time right away.
                        st_nxt.hs      = 1'b0;
                        st_nxt.ls      = 1'b1;
                        ev[EV_TRUNC] = 1'b1;
                    end
                end
                if (cnt_tick) begin
                    st_nxt.ls_seen = 1'b0;
                    st_nxt.blocked = 1'b0;
                end
                if (cnt_full) begin
                    // Full count: tri-state both switches.
                    st_nxt.hs      = 1'b0;
                    st_nxt.ls      = 1'b0;
                    st_nxt.hwait   = HICC_LOAD;
                    st_nxt.phase   = PH_HICCUP;
                    st_nxt.wait_on = 1'b0;
                    ev[EV_HICC]    = 1'b1;
                end
                if (!p.analog_ok) begin
                    st_nxt.phase = PH_IDLE;
                    st_nxt.valid = 1'b0;
                    st_nxt.hs    = 1'b0;
                    st_nxt.ls    = 1'b0;
                end
            end
            PH_HICCUP: begin
                // Wait three soft-starts with both switches off.
                st_nxt.hs      = 1'b0;
                st_nxt.ls      = 1'b0;
                st_nxt.ls_seen = 1'b0;
                st_nxt.blocked = 1'b0;
                if (st_r.hwait == '0) begin
                    cnt_clr         = 1'b1;
                    st_nxt.ss_pulse = 1'b1;
                    st_nxt.phase    = PH_RUN;
                end else begin
                    st_nxt.hwait = st_r.hwait - HW_W'(1);
                end
                if (!p.analog_ok) begin
                    st_nxt.phase = PH_IDLE;
                    st_nxt.valid = 1'b0;
                end
            end
            default: begin
                st_nxt.phase = PH_IDLE;
            end
        endcase

        // Register writes.
        if (bus.wr) begin
            case (bus.addr)
                REG_MASK: st_nxt.mask = bus.wdata[3:0];
                REG_CTRL: st_nxt.run  = bus.wdata[CTRL_RUN];
                default:  st_nxt.run  = st_r.run;
            endcase
        end

        // Register reads; a status read clears, new events win.
        st_nxt.rdata = 32'h0000_0000;
        st_nxt.status = st_r.status | ev;
        if (bus.rd) begin
            case (bus.addr)
                REG_STATUS: begin
                    st_nxt.rdata[3:0] = st_r.status;
                    st_nxt.status     = ev;
                end
                REG_MASK: st_nxt.rdata[3:0] = st_r.mask;
                REG_CTRL: st_nxt.rdata[CTRL_RUN] = st_r.run;
                REG_CONFIG: begin
                    st_nxt.rdata[CF_MV +: 12] = st_r.cfg.vout_mv;
                    st_nxt.rdata[CF_KHZ +: 10] = st_r.cfg.rate_khz;
                    st_nxt.rdata[CF_LIM +: 7]  = st_r.cfg.limit_da;
                end
                REG_STATE: begin
                    st_nxt.rdata[SR_CNT +: 4] = cnt;
                    st_nxt.rdata[SR_PH +: 2]  = st_r.phase;
                    st_nxt.rdata[SR_HS]       = st_r.hs;
                    st_nxt.rdata[SR_LS]       = st_r.ls;
                    st_nxt.rdata[SR_VAL]      = st_r.valid;
                end
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Level interrupt from unmasked sticky bits.
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    // State register with defined reset values.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r       <= '0;
            st_r.phase <= PH_IDLE;
            st_r.mask  <= MASK_RST;
            st_r.run   <= RUN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign hs_gate    = st_r.hs;
    assign ls_gate    = st_r.ls;
    assign ss_restart = st_r.ss_pulse;
    assign cfg_valid  = st_r.valid;
    assign cfg        = st_r.cfg;
    assign irq        = st_r.irq;
    assign rdata      = st_r.rdata;
endmodule

// ---- tb/bps_board.sv ----
// Board strap model: turns each strap level into its two sense reads.
`timescale 1ns/1ps
module bps_board (
    // Strap levels chosen by the bench.
    input  wire bps_pkg::bps_strap_e lvl [4],
    // Reads with pull-up and with pull-down.
    output bps_pkg::bps_sense_s      sns [4]
);
    import bps_pkg::*;
    // An open pin follows the applied pull; a tied pin ignores it.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            sns[i] = '{pu: lvl[i] != STRAP_LOW, pd: lvl[i] == STRAP_HIGH};
        end
    end
endmodule

// ---- tb/bps_top_monitor.sv ----
// Port checks of the protection and strap block.
`timescale 1ns/1ps
module bps_top_monitor #(
    parameter int unsigned SS_TIME_US = 2000 // Soft-start length in microseconds.
) (
    // Clock and reset.
    input wire logic               clk,
    input wire logic               resetn,
    // Watched ports.
    input wire bps_pkg::bps_pins_s pins,
    input wire bps_pkg::bps_bus_s  bus,
    input wire logic [31:0]        rdata,
    input wire logic               hs_gate,
    input wire logic               ls_gate,
    input wire logic               ss_restart,
    input wire logic               cfg_valid,
    input wire bps_pkg::bps_cfg_s  cfg,
    input wire logic               irq
);
    import bps_pkg::*;
    logic [4:0] hs_cnt_r; // High-side on time, saturating.
    // Counts how long the high side has stood on.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hs_cnt_r <= 5'h00;
        end else begin
            hs_cnt_r <= hs_gate ? hs_cnt_r + 5'(hs_cnt_r != 5'h1F) : 5'h00;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // A limit indication held well after blanking has ended.
    sequence s_hs_late;
        (hs_cnt_r > 5'h0C) ##0 pins.hs_valley_limit_strap [*5];
    endsequence
    a_thermal_off: assert property (pins.over_temp [*5] |-> ##2 !(hs_gate || ls_gate))
        else $error("gate on in over-temperature");
    a_ls_hold: assert property (pins.ls_valley_limit_strap [*6] |-> !$rose(hs_gate))
        else $error("turn-on under low-side limit");
    a_blank_hold: assert property ($rose(hs_gate) |-> ##2 hs_gate [*8])
        else $error("on time cut in blanking");
    a_trunc_fast: assert property (s_hs_late |-> ##[0:2] !hs_gate)
        else $error("limit did not cut on time");
    a_cfg_frozen: assert property (cfg_valid && $past(cfg_valid) |-> $stable(cfg))
        else $error("configuration moved");
    a_latch_restart: assert property ($rose(cfg_valid) |-> ss_restart)
        else $error("latch without restart");
    a_restart_off: assert property (ss_restart |=> !ss_restart && !hs_gate)
        else $error("bad restart");
    a_supply_drop: assert property (!pins.analog_ok [*5] |-> ##[0:2] !cfg_valid)
        else $error("straps kept without supply");
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
        else $error("read data without read");
endmodule

// ---- tb/tb_buck_protection_strap_logic.sv ----
// Self-checking bench of the protection and strap block.
`timescale 1ns/1ps
module tb_buck_protection_strap_logic;
    import bps_pkg::*;
    localparam bps_strap_e L = STRAP_LOW;  // Tied to ground.
    localparam bps_strap_e H = STRAP_HIGH; // Tied to the rail.
    localparam bps_strap_e Z = STRAP_OPEN; // Left open.
    // Strap tables and the values each selects.
    bps_strap_e  vh [9]  = '{L, L, H, H, L, Z, H, Z, Z};
    bps_strap_e  vl [9]  = '{L, H, L, H, Z, L, Z, H, Z};
    logic [11:0] mv [9]  = '{MV_3300, MV_2500, MV_1800, MV_1500, MV_1200, MV_1000, MV_900,
                             MV_800, MV_700};
    bps_strap_e  lims [3] = '{L, H, Z};
    bps_strap_e  rs [3]  = '{H, L, Z};
    logic [9:0]  khz [3] = '{RATE_HIGH_KHZ, RATE_LOW_KHZ, RATE_OPEN_KHZ};
    logic [6:0]  lda [3] = '{LIM_LOW_DA, LIM_HIGH_DA, LIM_OPEN_DA};
    logic        clk     = 1'b0;
    logic        resetn  = 1'b0;
    logic        a_ok = 1'b0, ot = 1'b0, ls = 1'b0, hs = 1'b0, pwm = 1'b0; // Indications.
    bps_strap_e  lvl [4] = '{default: L}; // Strap levels.
    bps_sense_s  sns [4];                 // Strap reads.
    bps_pins_s   pins;
    bps_bus_s    bus     = '0;
    logic [31:0] rdata;
    logic        hs_gate, ls_gate, ss_restart, cfg_valid, irq;
    bps_cfg_s    cfg;
    int          n_fail  = 0;
    int          tests_run = 0;
    assign pins = {a_ok, ot, ls, hs, pwm, sns[0], sns[1], sns[2], sns[3]};
    always #5 clk = ~clk;
    bps_board board (.lvl(lvl), .sns(sns));
    bps_top #(.SS_TIME_US(1)) dut (.clk(clk), .resetn(resetn), .pins(pins), .bus(bus),
        .rdata(rdata), .hs_gate(hs_gate), .ls_gate(ls_gate), .ss_restart(ss_restart),
        .cfg_valid(cfg_valid), .cfg(cfg), .irq(irq));
    // Counts a comparison and reports a mismatch.
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        tests_run++;
        if (got !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) bus <= '0;
    endtask
    // Reads one word and compares the masked bits in the answer cycle.
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk) bus <= '0;
        #1 chk("rdata", e, rdata & m);
    endtask
    // Waits a bounded time for high-side on, restart pulse or latched straps.
    task automatic wt(input int sel, input int lim);
        logic seen = 1'b0;
        repeat (lim) if (!seen) begin
            @(posedge clk) #1;
            seen = (sel == 0) ? hs_gate : (sel == 1) ? ss_restart : cfg_valid;
        end
        chk("wait", 1, seen);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        cyc(12);
        resetn <= 1'b1;
        rd(REG_MASK, 32'h0, 32'hF);
        rd(REG_CTRL, 32'h1, 32'h1);
        rd(5'h14, 32'h0, '1);
        $display("regs done");
        for (int i = 8; i >= 0; i--) begin
            int r;
            r = i < 2 ? 0 : i < 4 ? 1 : 2;
            @(posedge clk) a_ok <= 1'b0;
            lvl <= '{vh[i], vl[i], rs[r], lims[i % 3]};
            cyc(8);
            a_ok <= 1'b1;
            wt(2, 20);
            rd(REG_CONFIG, {3'h0, lda[i % 3], khz[r], mv[i]}, '1);
        end
        @(posedge clk) lvl <= '{Z, Z, Z, Z};
        cyc(8);
        rd(REG_CONFIG, {3'h0, LIM_LOW_DA, RATE_HIGH_KHZ, MV_3300}, '1);
        $display("straps done");
        @(posedge clk) pwm <= 1'b1;
        wt(0, 300);
        @(posedge clk) hs <= 1'b1;
        cyc(5);
        #1 chk("hs_gate", 1, hs_gate);
        cyc(10);
        #1 chk("hs_gate", 0, hs_gate);
        @(posedge clk) hs <= 1'b0;
        #1 chk("irq", 0, irq);
        wr(REG_MASK, 32'h4);
        cyc(2);
        #1 chk("irq", 1, irq);
        rd(REG_STATUS, 32'h4, 32'hF);
        cyc(2);
        #1 chk("irq", 0, irq);
        wt(0, 300);
        cyc(30);
        hs <= 1'b1;
        cyc(7);
        #1 chk("hs_gate", 0, hs_gate);
        @(posedge clk) hs <= 1'b0;
        rd(REG_STATE, 32'h0, 32'hF);
        $display("limits done");
        wt(0, 300);
        cyc(20);
        ot <= 1'b1;
        cyc(8);
        #1 chk("gates", 0, {hs_gate, ls_gate});
        rd(REG_STATUS, 32'h5, 32'hF);
        @(posedge clk) ot <= 1'b0;
        wt(1, 20);
        wt(0, 300);
        wr(REG_CTRL, 32'h0);
        cyc(2);
        #1 chk("gates", 0, {hs_gate, ls_gate});
        wr(REG_CTRL, 32'h1);
        $display("thermal done");
        @(posedge clk) ls <= 1'b1;
        cyc(300);
        rd(REG_STATE, 32'h80, 32'hC0);
        cyc(1680);
        rd(REG_STATE, {26'h0, PH_HICCUP, CNT_FULL}, 32'hFF);
        rd(REG_STATUS, 32'hA, 32'hA);
        @(posedge clk) ls <= 1'b0;
        wt(1, 400);
        rd(REG_STATE, {26'h0, PH_RUN, CNT_ZERO}, 32'h3F);
        $display("hiccup done");
        tally_and_finish();
    end
    // Watchdog against a hang.
    initial begin
        cyc(12000);
        n_fail++;
        tally_and_finish();
    end
endmodule
bind bps_top bps_top_monitor #(.SS_TIME_US(SS_TIME_US)) mon (.clk(clk), .resetn(resetn),
    .pins(pins), .bus(bus), .rdata(rdata), .hs_gate(hs_gate), .ls_gate(ls_gate),
    .ss_restart(ss_restart), .cfg_valid(cfg_valid), .cfg(cfg), .irq(irq));
